// ==== isl_inventory_slot_timing.sv ====
// Operation
// - select flag zero means sixteen slots, from zero
// - reply about 4352 carrier periods after EOF
// - modulation during wait restarts full wait
// - ignore modulation for 4384 periods plus nrt
// - SOF leaves sequence, frame is new request
// - addressed request answered only on UID match
// - new inventory restarts counting at slot zero
// - count slot EOFs, answer on mask+slot match
`timescale 1ns/1ps
module isl_inventory_slot_timing #(
    parameter int unsigned IGN_W = 18,
    parameter int unsigned NRT_CYCLES = isl_pkg::NRT_CYC,
    parameter int unsigned IGNORE_CYCLES = isl_pkg::IGNORE_BASE_CYC + isl_pkg::NRT_CYC
) (
    input wire logic MCLK,
    input wire logic RST_N,
    input wire logic EOF_PIN,
    input wire logic MOD_PIN,
    input wire logic SOF_DET,
    input wire logic REQ_VALID,
    input wire isl_pkg::isl_req_t REQ,
    output isl_pkg::isl_resp_t RESP,
    output logic IN_SEQUENCE,
    output logic MOD_IGNORE
);

    // ************************************************************
    // state
    // ************************************************************
    // all timing is counted in MCLK cycles:
    // - the response wait is the nominal carrier count turned into clock
    //   cycles, so a reply lands well inside the allowed band even with the
    //   two synchroniser cycles added in front of it
    // - the ignore window starts on the same edge and must outlast the wait
    //   plus the nominal reply time; a shorter window only suits simulation
    // - slot EOFs are taken only once the ignore window has run out, which
    //   bounds how fast a reader can step through the slots
    typedef struct packed {
        isl_pkg::isl_phase_t phase;
        logic in_seq;
        logic single_slot;
        logic mask_match;
        logic [isl_pkg::SLOT_W-1:0] uid_slot_bits;
        logic [isl_pkg::SLOT_W-1:0] slot;
        logic pend;
        logic pend_inv;
        logic [isl_pkg::WAIT_W-1:0] wait_cnt;
        logic [IGN_W-1:0] ign_cnt;
        logic eof_d;
        logic mod_d;
        isl_pkg::isl_resp_t resp;
    } isl_state_t;

    localparam logic [IGN_W-1:0] IGN_LOAD = IGN_W'(IGNORE_CYCLES);
    localparam logic [IGN_W-1:0] IGN_ZERO = '0;

    isl_state_t st;
    isl_state_t next_st;
    logic eof_s;
    logic mod_s;
    logic eof_rise;
    logic mod_rise;
    logic req_taken;
    logic first_slot_hit;
    logic plain_reply_due;
    logic [isl_pkg::SLOT_W-1:0] slot_inc;
    logic next_slot_hit;
    logic ign_run;
    logic wait_done;
    logic eof_taken;
    logic last_slot;

    // pins from the RF front end cross into MCLK here; the two flops add two
    // cycles to every reply timed from a slot EOF, still far inside the allowed timing band
    isl_sync u_sync_eof (
        .clk(MCLK),
        .rst_n(RST_N),
        .d(EOF_PIN),
        .q(eof_s)
    );

    isl_sync u_sync_mod (
        .clk(MCLK),
        .rst_n(RST_N),
        .d(MOD_PIN),
        .q(mod_s)
    );

    assign eof_rise = eof_s && !st.eof_d;
    assign mod_rise = mod_s && !st.mod_d;

    // ************************************************************
    // decode helpers
    // ************************************************************
    // a frame start in the same cycle wins over the request it would end
    assign req_taken = REQ_VALID && !SOF_DET;
    // slot zero opens right at the request EOF, so its match comes from REQ
    assign first_slot_hit = REQ.mask_match &&
        (REQ.slot_count_select || REQ.uid_slot_bits == isl_pkg::SLOT_FIRST);
    // a non-addressed request is answered by every tag that hears it
    assign plain_reply_due = !REQ.addressed || REQ.uid_match;
    // wraps only past the last slot, which ends the sequence first
    assign slot_inc = st.slot + 4'h1;
    assign next_slot_hit = st.mask_match && st.uid_slot_bits == slot_inc;
    assign ign_run = st.ign_cnt != IGN_ZERO;
    // the reply pulse leaves on the edge that would take the counter to zero
    assign wait_done = st.wait_cnt <= isl_pkg::WAIT_RST + 12'h001;
    // EOF edges inside the ignore window are treated as noise
    assign eof_taken = eof_rise && !ign_run && !st.single_slot;
    assign last_slot = st.slot == isl_pkg::SLOT_LAST;

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        next_st = st;
        next_st.eof_d = eof_s;
        next_st.mod_d = mod_s;
        next_st.resp.start = 1'b0;
        if (ign_run) begin
            next_st.ign_cnt = st.ign_cnt - IGN_W'(1);
        end
        if (SOF_DET) begin
            // a new frame ends any running sequence and cancels a pending reply
            next_st.in_seq = 1'b0;
            next_st.pend = 1'b0;
            next_st.phase = isl_pkg::ISL_IDLE;
        end else if (req_taken) begin
            next_st.ign_cnt = IGN_LOAD;
            next_st.wait_cnt = isl_pkg::RESP_WAIT_CYC;
            next_st.slot = isl_pkg::SLOT_FIRST;
            next_st.resp.inventory = REQ.is_inventory;
            next_st.pend_inv = REQ.is_inventory;
            if (REQ.is_inventory) begin
                next_st.in_seq = 1'b1;
                next_st.single_slot = REQ.slot_count_select;
                next_st.mask_match = REQ.mask_match;
                next_st.uid_slot_bits = REQ.uid_slot_bits;
                next_st.pend = first_slot_hit;
            end else begin
                next_st.in_seq = 1'b0;
                next_st.pend = plain_reply_due;
            end
            next_st.phase = isl_pkg::ISL_WAIT;
        end else begin
            unique case (st.phase)
                isl_pkg::ISL_IDLE: begin
                    next_st.phase = isl_pkg::ISL_IDLE;
                end
                isl_pkg::ISL_WAIT: begin
                    if (mod_rise) begin
                        // reader modulation is disregarded, but the full wait starts over
                        next_st.wait_cnt = isl_pkg::RESP_WAIT_CYC;
                    end else if (!wait_done) begin
                        next_st.wait_cnt = st.wait_cnt - 12'h001;
                    end else begin
                        // a wait with nothing pending still closes, so in a sequence the slot phase follows
                        next_st.wait_cnt = isl_pkg::WAIT_RST;
                        next_st.resp.start = st.pend;
                        next_st.resp.slot = st.slot;
                        next_st.pend = 1'b0;
                        next_st.phase = st.in_seq ? isl_pkg::ISL_SLOT : isl_pkg::ISL_IDLE;
                    end
                end
                isl_pkg::ISL_SLOT: begin
                    if (eof_taken) begin
                        if (last_slot) begin
                            // sequence exhausted, stay silent until the next request
                            next_st.in_seq = 1'b0;
                            next_st.phase = isl_pkg::ISL_IDLE;
                        end else begin
                            next_st.slot = slot_inc;
                            next_st.ign_cnt = IGN_LOAD;
                            next_st.wait_cnt = isl_pkg::RESP_WAIT_CYC;
                            next_st.pend = next_slot_hit;
                            next_st.phase = isl_pkg::ISL_WAIT;
                        end
                    end else if (st.single_slot) begin
                        // one-slot inventory is over once its only slot has passed
                        next_st.in_seq = 1'b0;
                        next_st.phase = isl_pkg::ISL_IDLE;
                    end
                end
                default: begin
                    next_st.phase = isl_pkg::ISL_IDLE;
                end
            endcase
        end
    end

    // ************************************************************
    // registers
    // ************************************************************
    // one register stage holds every bit of state; reset clears it all, so
    // the edge detectors start at the idle level of their pins and no false
    // EOF or modulation edge follows reset
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    // reply fields and sequence flag come straight from the state register;
    // the ignore flag is a compare on the registered counter
    assign RESP = st.resp;
    assign IN_SEQUENCE = st.in_seq;
    assign MOD_IGNORE = ign_run;

endmodule // isl_inventory_slot_timing

// ==== isl_pkg.sv ====
package isl_pkg;

    // ************************************************************
    // clock and carrier
    // ************************************************************
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned FC_HZ = 13_560_000;

    // ************************************************************
    // response timing, in carrier periods and in clock cycles
    // ************************************************************
    localparam int unsigned RESP_WAIT_MIN_FC = 4320;
    localparam int unsigned RESP_WAIT_NOM_FC = 4352;
    localparam int unsigned RESP_WAIT_MAX_FC = 4384;
    localparam longint unsigned RESP_WAIT_CYC_L =
        (longint'(RESP_WAIT_NOM_FC) * CLK_HZ) / FC_HZ;
    localparam longint unsigned IGNORE_BASE_CYC_L =
        (longint'(RESP_WAIT_MAX_FC) * CLK_HZ + FC_HZ - 1) / FC_HZ;
    localparam int unsigned WAIT_W = 12;
    localparam logic [WAIT_W-1:0] RESP_WAIT_CYC = WAIT_W'(RESP_WAIT_CYC_L);
    localparam int unsigned IGNORE_BASE_CYC = 32'(IGNORE_BASE_CYC_L);
    // nominal tag response time at the low data rate
    localparam int unsigned NRT_NS = 15_708_160;
    localparam int unsigned CLK_NS = 1_000_000_000 / CLK_HZ;
    localparam int unsigned NRT_CYC = (NRT_NS + CLK_NS - 1) / CLK_NS;

    // ************************************************************
    // slots and reset values
    // ************************************************************
    localparam int unsigned SLOT_W = 4;
    localparam logic [SLOT_W-1:0] SLOT_FIRST = 4'h0;
    localparam logic [SLOT_W-1:0] SLOT_LAST = 4'hF;
    localparam logic [WAIT_W-1:0] WAIT_RST = 12'h000;

    typedef enum logic [1:0] {
        ISL_IDLE = 2'b00,
        ISL_WAIT = 2'b01,
        ISL_SLOT = 2'b10
    } isl_phase_t;

    // request decoded by the frame receiver, offered with its closing EOF edge
    typedef struct packed {
        logic is_inventory;
        logic slot_count_select;
        logic addressed;
        logic uid_match;
        logic mask_match;
        logic [SLOT_W-1:0] uid_slot_bits;
    } isl_req_t;

    typedef struct packed {
        logic start;
        logic inventory;
        logic [SLOT_W-1:0] slot;
    } isl_resp_t;

endpackage

// ==== isl_sync.sv ====
`timescale 1ns/1ps
module isl_sync (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic d,
    output logic q
);
    logic meta;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= 1'b0;
            q <= 1'b0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule // isl_sync

// ==== isl_checker_assertions.sv ====
`timescale 1ns/1ps
module isl_checker (
    input wire logic MCLK,
    input wire logic RST_N,
    input wire logic EOF_PIN,
    input wire logic SOF_DET,
    input wire logic REQ_VALID,
    input wire isl_pkg::isl_req_t REQ,
    input wire isl_pkg::isl_resp_t RESP,
    input wire logic IN_SEQUENCE,
    input wire logic MOD_IGNORE
);
    // ****
    // reply launch distance
    // ****
    logic [11:0] since;
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) since <= 12'h000;
        else if (REQ_VALID || $rose(EOF_PIN)) since <= 12'h000;
        else if (since != 12'hFFF) since <= since + 12'h001;
    end
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_N);
    a_start_single: assert property (RESP.start |=> !RESP.start)
        else $error("reply start too long");
    a_reply_min: assert property (RESP.start |-> since >= 12'hC72)
        else $error("reply too early");
    a_reply_in_ign: assert property (RESP.start |-> MOD_IGNORE)
        else $error("reply outside ignore window");
    a_ignore_on: assert property (REQ_VALID && !SOF_DET |=> MOD_IGNORE)
        else $error("ignore window not started");
    a_ignore_hold: assert property ($rose(MOD_IGNORE) |-> MOD_IGNORE[*8])
        else $error("ignore window cut short");
    a_inv_enter: assert property (REQ_VALID && !SOF_DET && REQ.is_inventory |=> IN_SEQUENCE)
        else $error("sequence not entered");
    a_seq_cause: assert property ($rose(IN_SEQUENCE) |-> $past(REQ_VALID))
        else $error("sequence without request");
    a_sof_exit: assert property (SOF_DET |=> !IN_SEQUENCE ##0 (!RESP.start)[*8])
        else $error("frame start did not end sequence");
endmodule // isl_checker

// ==== isl_reader.sv ====
`timescale 1ns/1ps
module isl_reader (
    input wire logic clk,
    output logic eof_pin,
    output logic mod_pin
);
    // ****
    // reader side
    // ****
    // pulses last half a link period; wait is long enough for reply plus gap
    localparam int HALF_NS = 400;
    localparam int SLOT_WAIT = 4500;
    initial begin
        eof_pin = 1'b0;
        mod_pin = 1'b0;
    end
    task automatic send_eof();
        eof_pin = 1'b1;
        #HALF_NS eof_pin = 1'b0;
    endtask
    task automatic next_slot();
        repeat (SLOT_WAIT) @(negedge clk);
        send_eof();
    endtask
    task automatic mod_burst();
        mod_pin = 1'b1;
        #HALF_NS mod_pin = 1'b0;
    endtask
endmodule // isl_reader

// ==== test_inventory_slot_timing.sv ====
`timescale 1ns/1ps
module test_inventory_slot_timing;
    logic MCLK, RST_N, EOF_PIN, MOD_PIN, SOF_DET, REQ_VALID, IN_SEQUENCE, MOD_IGNORE;
    isl_pkg::isl_req_t REQ;
    isl_pkg::isl_resp_t RESP;
    logic [5:0] expq[$];
    logic [5:0] x;
    logic [3:0] u;
    int n_fail = 0;
    int comparisons = 0;
    int seed = 32'hd07e;
    isl_inventory_slot_timing #(.IGNORE_CYCLES(4400)) i_dut (.MCLK(MCLK), .RST_N(RST_N),
        .EOF_PIN(EOF_PIN), .MOD_PIN(MOD_PIN), .SOF_DET(SOF_DET), .REQ_VALID(REQ_VALID),
        .REQ(REQ), .RESP(RESP), .IN_SEQUENCE(IN_SEQUENCE), .MOD_IGNORE(MOD_IGNORE));
    isl_reader i_rdr (.clk(MCLK), .eof_pin(EOF_PIN), .mod_pin(MOD_PIN));
    // ****
    // tasks
    // ****
    task automatic check(input logic [5:0] seen, input logic [5:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // request fields: inventory, one slot, addressed, uid match, mask match, uid bits
    task automatic send_req(input isl_pkg::isl_req_t r);
        @(negedge MCLK);
        REQ = r;
        REQ_VALID = 1'b1;
        @(negedge MCLK);
        REQ_VALID = 1'b0;
    endtask
    task automatic drain(input int n);
        int i;
        for (i = 0; i < n && expq.size() != 0; i++) @(negedge MCLK);
        if (expq.size() != 0) begin
            n_fail++;
            end_of_test();
        end
    endtask
    // slot is compared only where bit 5 of the note asks for it
    always @(negedge MCLK) begin
        if (RESP.start === 1'b1) begin
            if (expq.size() == 0) check(6'h3F, 6'h00);
            else begin
                x = expq.pop_front();
                check({x[5], RESP.inventory, RESP.slot & {4{x[5]}}}, x);
            end
        end
    end
    initial begin
        MCLK = 1'b0;
        forever #50 MCLK = ~MCLK;
    end
    // ****
    // scenarios
    // ****
    initial begin
        RST_N = 1'b0;
        SOF_DET = 1'b0;
        REQ_VALID = 1'b0;
        REQ = '0;
        repeat (16) @(negedge MCLK);
        RST_N = 1'b1;
        u = 4'($random(seed));
        expq.push_back({2'b11, u});
        send_req({5'b10001, u});
        // one extra end-of-frame after the last slot must stay unanswered
        for (int s = 0; s < 16; s++) i_rdr.next_slot();
        repeat (3300) @(negedge MCLK);
        check({5'h00, IN_SEQUENCE}, 6'h00);
        check(6'(expq.size()), 6'h00);
        expq.push_back(6'h30);
        send_req({5'b11001, 4'h7});
        repeat (1000) @(negedge MCLK);
        i_rdr.mod_burst();
        repeat (2300) @(negedge MCLK);
        check(6'(expq.size()), 6'h01);
        drain(1000);
        send_req({5'b10001, 4'h0});
        repeat (100) @(negedge MCLK);
        SOF_DET = 1'b1;
        @(negedge MCLK);
        SOF_DET = 1'b0;
        @(negedge MCLK);
        check({5'h00, IN_SEQUENCE}, 6'h00);
        send_req({5'b00100, 4'h0});
        repeat (3400) @(negedge MCLK);
        expq.push_back(6'h00);
        send_req({5'b00110, 4'h0});
        drain(3400);
        end_of_test();
    end
endmodule // test_inventory_slot_timing
bind isl_inventory_slot_timing isl_checker i_chk (.MCLK(MCLK), .RST_N(RST_N),
    .EOF_PIN(EOF_PIN), .SOF_DET(SOF_DET), .REQ_VALID(REQ_VALID), .REQ(REQ), .RESP(RESP),
    .IN_SEQUENCE(IN_SEQUENCE), .MOD_IGNORE(MOD_IGNORE));
